// file: verilog/bdm_pkg.sv
/*
 * constants for the banked data memory: map offsets, region bounds,
 * reset values and array sizes.
 * assumes an 8-bit core data path and an 8-bit data address.
 */
package bdm_pkg;
    localparam logic [7:0] OFS_IND0 = 8'h00;
    localparam logic [7:0] OFS_PTR0 = 8'h01;
    localparam logic [7:0] OFS_IND1 = 8'h02;
    localparam logic [7:0] OFS_PTR1 = 8'h03;
    localparam logic [7:0] OFS_BANK = 8'h04;
    localparam logic [7:0] OFS_ACC = 8'h05;
    localparam logic [7:0] OFS_PERI_LO = 8'h06;
    localparam logic [7:0] OFS_PERI_HI = 8'h34;
    localparam logic [7:0] OFS_GAP_A = 8'h09;
    localparam logic [7:0] OFS_GAP_B = 8'h1f;
    localparam logic [7:0] OFS_GAP_C_LO = 8'h2a;
    localparam logic [7:0] OFS_GAP_C_HI = 8'h2c;
    localparam logic [7:0] OFS_GAP_D = 8'h2f;
    localparam logic [7:0] GP_BASE = 8'h40;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam logic [7:0] RST_PTR = 8'h00;
    localparam logic [7:0] RST_BANK = 8'h00;
    localparam logic [7:0] RST_ACC = 8'h00;
    localparam int BANK_BYTES = 192;
    localparam int BANK_COUNT = 2;
    localparam int RAM_AW = 9;
    localparam int BANK_SEL_BIT = 0;
endpackage

// file: verilog/bdm_ram_if.sv
/*
 * carrier between the address decoder and the general purpose ram.
 * assumes both ends sit on the same clock.
 */
`timescale 1ns/1ps
interface bdm_ram_if;
    logic we;
    logic [8:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctl (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface // bdm_ram_if

// file: verilog/bdm_gp_ram.sv
/*
 * general purpose ram: both banks in one array, bank 1 at a 192-entry
 * offset. assumes the decoder only presents in-range addresses.
 */
`timescale 1ns/1ps
module bdm_gp_ram
    import bdm_pkg::*;
#(
    parameter int DEPTH = BANK_BYTES * BANK_COUNT
) (
    input wire logic clk, // core clock
    input wire logic ce, // clock enable
    bdm_ram_if.mem bus // access port
);
    logic [7:0] mem_q [DEPTH];

    // asynchronous read lets the decoder do bit updates in one cycle
    assign bus.rdata = mem_q[bus.addr];

    // write port, frozen with the clock enable
    always_ff @(posedge clk) begin
        if (ce && bus.we) begin
            mem_q[bus.addr] <= bus.wdata;
        end
    end
endmodule // bdm_gp_ram

// file: verilog/bdm_data_mem.sv
/*
 * data memory decoder: pointer registers, bank select, accumulator,
 * indirect access, peripheral forwarding and the banked ram.
 * assumes peripherals answer sfr_rdata combinationally from sfr_addr_q
 * and apply forwarded writes and bit updates themselves.
 */
`timescale 1ns/1ps

// Function
// - two ram banks of 192 bytes sit at 40h-ffh, picked by bank select 0 or 1.
// - addresses below 40h reach the same locations in either bank.
// - unimplemented locations below 40h, 35h-3fh among them, read zero.
// - every location can be read and written back as an alu operand.
// - single bit set and clear work on every bit except protected ones.
// - 00h and 02h have no storage and redirect through pointers 01h and 03h.
// - an indirect read whose pointer names an indirect location gives 00h.
// - an indirect write whose pointer names an indirect location does nothing.
// - no move from one indirect location to the other is offered.
// - each memory pointer is 8 bits; the bank select still picks the ram bank.
// - the accumulator is location 05h and also takes immediate loads.
// - memory to memory moves go through the accumulator only.
module bdm_data_mem
    import bdm_pkg::*;
(
    input wire logic clk, // core clock, 250 mhz
    input wire logic rstn, // async reset, active low
    input wire logic ce, // clock enable, freezes all state
    input wire logic req_rd, // read request
    input wire logic req_wr, // byte write request
    input wire logic req_bset, // bit set request
    input wire logic req_bclr, // bit clear request
    input wire logic [7:0] req_addr, // data address
    input wire logic [7:0] req_wdata, // write data
    input wire logic [2:0] req_bit, // bit index for set/clear
    input wire logic acc_load, // immediate load of accumulator
    input wire logic [7:0] acc_imm, // immediate operand
    input wire logic [7:0] sfr_rdata, // peripheral read data
    output logic [7:0] rdata_q, // read data
    output logic rvalid_q, // read data valid pulse
    output logic [7:0] accumulator_q, // accumulator value
    output logic [7:0] sfr_addr_q, // peripheral address
    output logic sfr_rd_q, // peripheral read strobe
    output logic sfr_wr_q, // peripheral write strobe
    output logic sfr_bset_q, // peripheral bit set strobe
    output logic sfr_bclr_q, // peripheral bit clear strobe
    output logic [2:0] sfr_bit_q, // peripheral bit index
    output logic [7:0] sfr_wdata_q // peripheral write data
);
    // request stage
    logic s1_rd_q, s1_wr_q, s1_bset_q, s1_bclr_q;
    logic [7:0] s1_addr_q, s1_wdata_q;
    logic [2:0] s1_bit_q;
    // answer stage
    logic s2_rd_q, s2_zero_q, s2_sfr_q;
    logic [7:0] s2_val_q;
    // mapped registers
    logic [7:0] memory_pointer_zero_q, memory_pointer_one_q;
    logic [7:0] ram_bank_select_q;

    bdm_ram_if ram_bus ();

    bdm_gp_ram u_ram (
        .clk (clk),
        .ce (ce),
        .bus (ram_bus)
    );

    // peripheral slots with a register behind them; gaps read zero
    function automatic logic peri_present(input logic [7:0] a);
        logic in_range;
        logic in_gap;
        in_range = (a >= OFS_PERI_LO) && (a <= OFS_PERI_HI);
        in_gap = (a == OFS_GAP_A) || (a == OFS_GAP_B) || (a == OFS_GAP_D) ||
                 ((a >= OFS_GAP_C_LO) && (a <= OFS_GAP_C_HI));
        peri_present = in_range && !in_gap;
    endfunction

    function automatic logic is_indirect(input logic [7:0] a);
        is_indirect = (a == OFS_IND0) || (a == OFS_IND1);
    endfunction

    // redirect through the pointers, full 8-bit address each
    wire ind_acc = is_indirect(s1_addr_q);
    wire [7:0] eff_addr = (s1_addr_q == OFS_IND0) ? memory_pointer_zero_q :
                          (s1_addr_q == OFS_IND1) ? memory_pointer_one_q :
                          s1_addr_q;
    // a pointer naming an indirect slot: read zero, write nothing
    wire self_ref = ind_acc && is_indirect(eff_addr);
    wire any_wr = s1_wr_q || s1_bset_q || s1_bclr_q;
    // self-reference must reach no register either, or a pointer
    // naming an indirect slot would corrupt the low map
    wire do_wr = any_wr && !self_ref;
    // region decode on the effective address
    wire in_gp = (eff_addr >= GP_BASE);
    // low region ignores the bank register entirely
    wire in_sfr = !in_gp && peri_present(eff_addr);
    wire hit_p0 = (eff_addr == OFS_PTR0);
    wire hit_p1 = (eff_addr == OFS_PTR1);
    wire hit_bk = (eff_addr == OFS_BANK);
    wire hit_acc = (eff_addr == OFS_ACC);
    wire hit_loc = hit_p0 || hit_p1 || hit_bk || hit_acc;
    wire bank = ram_bank_select_q[BANK_SEL_BIT];
    wire [7:0] gp_off = eff_addr - GP_BASE;
    // bank applies to direct and pointer-based accesses alike
    // the top bank starts 192 bytes up and fills the rest of the 384-entry array
    assign ram_bus.addr = bank ? 9'(gp_off) + 9'(BANK_BYTES)
                               : 9'(gp_off);

    // local register value; only meaningful while hit_loc is set
    wire [7:0] reg_val = hit_p0 ? memory_pointer_zero_q :
                         hit_p1 ? memory_pointer_one_q :
                         hit_bk ? ram_bank_select_q : accumulator_q;
    // current local value; peripheral values come back later
    wire [7:0] loc_val = in_gp ? ram_bus.rdata :
                         hit_loc ? reg_val : READ_ZERO;
    // bit update; no local bit is protected, peripherals guard their own
    wire [7:0] bit_mask = 8'h01 << s1_bit_q;
    wire [7:0] new_val = s1_bset_q ? (loc_val | bit_mask) :
                         s1_bclr_q ? (loc_val & ~bit_mask) :
                         s1_wdata_q;
    wire loc_wr = do_wr && !in_sfr;
    assign ram_bus.we = loc_wr && in_gp;
    assign ram_bus.wdata = new_val;
    wire sfr_go = in_sfr && !self_ref;

    // one request per cycle; only a single address is carried, so a
    // move between the two indirect slots cannot be expressed
    // and copies have to be read to the accumulator then written
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_rd_q <= 1'b0;
            s1_wr_q <= 1'b0;
            s1_bset_q <= 1'b0;
            s1_bclr_q <= 1'b0;
            s1_addr_q <= 8'h00;
            s1_wdata_q <= 8'h00;
            s1_bit_q <= 3'h0;
        end else if (ce) begin
            s1_rd_q <= req_rd;
            s1_wr_q <= req_wr;
            s1_bset_q <= req_bset;
            s1_bclr_q <= req_bclr;
            s1_addr_q <= req_addr;
            s1_wdata_q <= req_wdata;
            s1_bit_q <= req_bit;
        end
    end

    // pointer and bank registers, written like any location
    // all bank select bits are kept and read back; bit 0 steers the ram
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            memory_pointer_zero_q <= RST_PTR;
            memory_pointer_one_q <= RST_PTR;
            ram_bank_select_q <= RST_BANK;
        end else if (ce && loc_wr) begin
            if (hit_p0) memory_pointer_zero_q <= new_val;
            if (hit_p1) memory_pointer_one_q <= new_val;
            if (hit_bk) ram_bank_select_q <= new_val;
        end
    end

    // immediate load wins: it belongs to a later instruction
    wire [7:0] acc_d = acc_load ? acc_imm :
                       (loc_wr && hit_acc) ? new_val : accumulator_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            accumulator_q <= RST_ACC;
        end else if (ce) begin
            accumulator_q <= acc_d;
        end
    end

    // forward peripheral accesses one cycle on, from flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sfr_addr_q <= 8'h00;
            sfr_rd_q <= 1'b0;
            sfr_wr_q <= 1'b0;
            sfr_bset_q <= 1'b0;
            sfr_bclr_q <= 1'b0;
            sfr_bit_q <= 3'h0;
            sfr_wdata_q <= 8'h00;
        end else if (ce) begin
            sfr_addr_q <= eff_addr;
            sfr_rd_q <= sfr_go && s1_rd_q;
            sfr_wr_q <= sfr_go && s1_wr_q;
            sfr_bset_q <= sfr_go && s1_bset_q;
            sfr_bclr_q <= sfr_go && s1_bclr_q;
            sfr_bit_q <= s1_bit_q;
            sfr_wdata_q <= s1_wdata_q;
        end
    end

    // answer stage: local value held, peripheral value merged late
    // a peripheral answers from sfr_addr_q one cycle on, so only a flag
    // travels here and the value is taken when it is really on sfr_rdata
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s2_rd_q <= 1'b0;
            s2_zero_q <= 1'b0;
            s2_sfr_q <= 1'b0;
            s2_val_q <= 8'h00;
        end else if (ce) begin
            s2_rd_q <= s1_rd_q;
            s2_zero_q <= self_ref;
            s2_sfr_q <= in_sfr;
            s2_val_q <= loc_val;
        end
    end

    // read data lands three cycles after the request cycle
    // rdata_q holds between reads so a slow consumer still sees the byte
    wire [7:0] rd_d = s2_zero_q ? READ_ZERO :
                      s2_sfr_q ? sfr_rdata : s2_val_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else if (ce) begin
            rvalid_q <= s2_rd_q;
            if (s2_rd_q) rdata_q <= rd_d;
        end
    end
endmodule // bdm_data_mem

// file: verif/bdm_data_mem_assertions.sv
/* port assertions for bdm_data_mem, bound into every instance.
   assumes ce stays high while a request is in flight. */
`timescale 1ns/1ps
module bdm_data_mem_chk
    import bdm_pkg::*;
(
    input wire logic clk, // clock
    input wire logic rstn, // reset
    input wire logic ce, // enable
    input wire logic req_rd, // read
    input wire logic req_wr, // write
    input wire logic req_bset, // bit set
    input wire logic req_bclr, // bit clear
    input wire logic [7:0] req_addr, // address
    input wire logic [7:0] req_wdata, // data
    input wire logic [2:0] req_bit, // bit
    input wire logic acc_load, // load
    input wire logic [7:0] acc_imm, // immediate
    input wire logic rvalid_q, // valid
    input wire logic [7:0] rdata_q, // data
    input wire logic [7:0] accumulator_q, // acc
    input wire logic [7:0] sfr_addr_q, // address
    input wire logic sfr_rd_q, // read
    input wire logic sfr_wr_q, // write
    input wire logic sfr_bset_q, // bit set
    input wire logic sfr_bclr_q, // bit clear
    input wire logic [2:0] sfr_bit_q, // bit
    input wire logic [7:0] sfr_wdata_q // data
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // direct address classes; indirect slots never count as peripheral
    wire lo = req_addr >= OFS_PERI_LO && req_addr <= OFS_PERI_HI;
    wire hole = req_addr inside {OFS_GAP_A, OFS_GAP_B,
        [OFS_GAP_C_LO:OFS_GAP_C_HI], OFS_GAP_D};
    wire per = lo && !hole;
    wire unused = req_addr > OFS_PERI_HI && req_addr < GP_BASE;
    a_read_answer_time: assert property (
        (ce && req_rd) ##1 ce ##1 ce |=> rvalid_q) else $error("late read");
    a_valid_has_cause: assert property (
        rvalid_q |-> $past(req_rd, 3)) else $error("stray valid");
    a_imm_load: assert property (
        ce && acc_load |=> accumulator_q == $past(acc_imm))
        else $error("immediate lost");
    a_freeze_state: assert property (
        !ce |=> $stable(accumulator_q) && $stable(sfr_addr_q))
        else $error("state moved while frozen");
    a_periph_read: assert property (
        (ce && req_rd && per) ##1 ce |=> sfr_rd_q
        && sfr_addr_q == $past(req_addr, 2)) else $error("no periph read");
    a_ram_no_fwd: assert property (
        (ce && req_rd && req_addr >= GP_BASE) ##1 ce |=> !sfr_rd_q)
        else $error("ram read forwarded");
    a_unused_no_wr: assert property (
        (ce && req_wr && unused) ##1 ce |=> !sfr_wr_q)
        else $error("unused write forwarded");
    a_unused_zero: assert property (
        (ce && req_rd && unused) ##1 ce ##1 ce |=> rdata_q == READ_ZERO)
        else $error("unused read not zero");
    a_periph_write: assert property (
        (ce && req_wr && per) ##1 ce |=> sfr_wr_q
        && sfr_wdata_q == $past(req_wdata, 2)) else $error("no periph write");
    a_periph_bset: assert property (
        (ce && req_bset && per) ##1 ce |=> sfr_bset_q
        && sfr_bit_q == $past(req_bit, 2)) else $error("no periph bit set");
    a_periph_bclr: assert property (
        (ce && req_bclr && per) ##1 ce |=> sfr_bclr_q
        && sfr_bit_q == $past(req_bit, 2)) else $error("no periph bit clear");
endmodule // bdm_data_mem_chk
bind bdm_data_mem bdm_data_mem_chk i_chk (.*);

// file: verif/test_banked_data_memory_indirect_access.sv
/* self-checking bench for bdm_data_mem with a reference model.
   assumes the checker file binds itself into the design. */
`timescale 1ns/1ps
module test_banked_data_memory_indirect_access;
    import bdm_pkg::*;
    logic clk = 0, rstn = 0, ce = 1, rd = 0, wr = 0, bs = 0, bc = 0, ld = 0;
    logic [7:0] addr = 0, wd = 0, imm = 0, rdata, acc, sa, swd;
    logic [2:0] bit_i = 0, sbit;
    logic rv, srd, swr, sbs, sbc;
    logic [7:0] m [512];
    logic [7:0] p0 = 0, p1 = 0, bk = 0, ac = 0;
    logic [7:0] expq [$];
    int num_errors = 0, num_checks = 0;
    wire [7:0] sfr_val = sa ^ 8'h5a; // peripherals answer from address
    always #2 clk = ~clk;
    bdm_data_mem i_dut (.clk(clk), .rstn(rstn), .ce(ce), .req_rd(rd),
        .req_wr(wr), .req_bset(bs), .req_bclr(bc), .req_addr(addr),
        .req_wdata(wd), .req_bit(bit_i), .acc_load(ld), .acc_imm(imm),
        .sfr_rdata(sfr_val), .rdata_q(rdata), .rvalid_q(rv),
        .accumulator_q(acc), .sfr_addr_q(sa), .sfr_rd_q(srd), .sfr_wr_q(swr),
        .sfr_bset_q(sbs), .sfr_bclr_q(sbc), .sfr_bit_q(sbit),
        .sfr_wdata_q(swd));
    // model: effective address with bank bit on top
    function automatic logic [8:0] ea(input logic [7:0] a);
        logic [7:0] e;
        e = a == OFS_IND0 ? p0 : a == OFS_IND1 ? p1 : a;
        return {bk[0], e};
    endfunction
    function automatic logic per(input logic [7:0] a);
        return a >= OFS_PERI_LO && a <= OFS_PERI_HI
            && !(a inside {OFS_GAP_A, OFS_GAP_B,
                [OFS_GAP_C_LO:OFS_GAP_C_HI], OFS_GAP_D});
    endfunction
    // self-referencing pointers land in default, so read zero
    function automatic logic [7:0] peek(input logic [7:0] a);
        logic [8:0] x;
        x = ea(a);
        if (x[7:0] >= GP_BASE) return m[x];
        case (x[7:0])
            OFS_PTR0: return p0;
            OFS_PTR1: return p1;
            OFS_BANK: return bk;
            OFS_ACC: return ac;
            default: return per(x[7:0]) ? x[7:0] ^ 8'h5a : READ_ZERO;
        endcase
    endfunction
    // writes to peripherals, holes and self-reference leave no trace
    task automatic poke(input logic [7:0] a, input logic [7:0] d);
        logic [8:0] x;
        x = ea(a);
        if (x[7:0] >= GP_BASE) m[x] = d;
        else if (x[7:0] == OFS_PTR0) p0 = d;
        else if (x[7:0] == OFS_PTR1) p1 = d;
        else if (x[7:0] == OFS_BANK) bk = d;
        else if (x[7:0] == OFS_ACC) ac = d;
    endtask
    task automatic op(input logic r, w, s, c, l, input logic [7:0] a, d,
        input logic [2:0] b);
        @(negedge clk);
        {rd, wr, bs, bc, ld, addr, wd, imm, bit_i} = {r, w, s, c, l, a, d, d, b};
        if (r) expq.push_back(peek(a));
        if (w) poke(a, d);
        if (s) poke(a, peek(a) | (8'h01 << b));
        if (c) poke(a, peek(a) & ~(8'h01 << b));
        if (l) ac = d;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // freeze: an immediate load with ce low must not reach the accumulator
    task automatic pause();
        op(0, 0, 0, 0, 0, 0, 0, 0);
        repeat (4) @(negedge clk);
        {ce, ld, imm} = {1'b0, 1'b1, ~ac};
        @(negedge clk);
        {ce, ld} = 2'b10;
        op(1, 0, 0, 0, 0, OFS_ACC, 0, 0);
    endtask
    // answers pair with the oldest outstanding read
    always @(posedge clk) begin
        #1;
        if (rv === 1'b1 && expq.size() == 0)
            check(8'h01, 8'h00);
        else if (rv === 1'b1)
            check(rdata, expq.pop_front());
    end
    initial begin
        #100000;
        num_errors++;
        test_done();
    end
    initial begin
        int r;
        logic [7:0] a, d;
        void'($urandom(32'h1bc13684));
        repeat (16) @(posedge clk);
        @(negedge clk) rstn = 1;
        check(acc, RST_ACC);
        for (int i = 1; i < 6; i++) op(1, 0, 0, 0, 0, 8'(i), 0, 0);
        // fill both banks so every later read has a known value
        for (int b = 0; b < 2; b++) begin
            op(0, 1, 0, 0, 0, OFS_BANK, 8'(b), 0);
            for (int i = 64; i < 256; i++)
                op(0, 1, 0, 0, 0, 8'(i), 8'($urandom), 0);
        end
        // back to back mix, pointers biased towards low slots
        for (int n = 0; n < 3000; n++) begin
            r = $urandom % 3;
            a = r == 0 ? 8'($urandom % 6) : r == 1 ? 8'($urandom % 64)
                : 8'(64 + $urandom % 192);
            d = 8'($urandom);
            if (a == OFS_PTR0 || a == OFS_PTR1) d = r ? d : 8'($urandom % 6);
            if (a == OFS_BANK) d = d & 8'h01;
            r = $urandom % 5;
            op(r == 0, r == 1, r == 2, r == 3, r == 4, a, d, 3'($urandom));
            if (n % 500 == 499) pause();
        end
        op(0, 0, 0, 0, 0, 0, 0, 0);
        repeat (8) @(negedge clk);
        check(8'(expq.size()), 8'h00);
        test_done();
    end
endmodule // test_banked_data_memory_indirect_access
